// ===== dv/strobe_load.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Opto-coupled strobe load
// ****************************************
// The lamp flashes while its opto-coupler is closed. The model only listens:
// the opto output has no reply path, so it can never be kinder than a real load.
module strobe_load (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic closed,
  output var  int   flashes,
  output var  int   last_width
);
  logic closed_q;
  int   run_q;

  // Count closures and time each closed stretch in clock cycles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      closed_q   <= 1'b0;
      run_q      <= 0;
      flashes    <= 0;
      last_width <= 0;
    end else begin
      closed_q <= closed;
      if (closed && !closed_q) begin
        flashes <= flashes + 1;
      end
      run_q <= closed ? run_q + 1 : 0;
      if (!closed && closed_q) begin
        last_width <= run_q;  // Width is known only once the lamp goes dark
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/test_event_output_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", n, b, a); end end
module test_event_output_pulse_gen
  import pulse_gen_pkg::*;
;
  logic ref_clk, rst_n, cfg_write, output_index, output_drive_mode, mode_write;
  logic line_active_polarity, static_output_level, pulse_active_polarity;
  logic input_line1, input_line2;
  logic [SRC_W-1:0]  pulse_event_source;
  logic [3:0]        output_event_mode_select;
  logic [TIME_W-1:0] line_pulse_delay_us, line_pulse_width_us, pulse_delay_us, pulse_width_us;
  logic [7:0]        ev;
  logic [1:0]        output_closed_q;
  logic              rejected_trigger_event_q;
  int                n_fail, checked, fl0, w0, fl1, w1, base;
  int                codes[6] = '{2, 6, 7, 8, 9, 10};
  int                evts[6]  = '{1, 3, 4, 5, 6, 7};

  assign input_line1 = ev[6];
  assign input_line2 = ev[7];

  event_output_pulse_gen event_output_pulse_gen_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_write(cfg_write), .output_index(output_index),
    .output_drive_mode(output_drive_mode), .pulse_event_source(pulse_event_source),
    .line_active_polarity(line_active_polarity), .line_pulse_delay_us(line_pulse_delay_us),
    .line_pulse_width_us(line_pulse_width_us), .static_output_level(static_output_level),
    .mode_write(mode_write), .output_event_mode_select(output_event_mode_select),
    .pulse_delay_us(pulse_delay_us), .pulse_width_us(pulse_width_us),
    .pulse_active_polarity(pulse_active_polarity), .trigger_in(ev[0]),
    .exposure_start(ev[1]), .exposure_end(ev[2]), .readout_start(ev[3]),
    .readout_end(ev[4]), .acq_stop_sw(ev[5]), .input_line1(input_line1),
    .input_line2(input_line2), .output_closed_q(output_closed_q),
    .rejected_trigger_event_q(rejected_trigger_event_q));

  strobe_load strobe_load_inst0 (.ref_clk(ref_clk), .rst_n(rst_n),
    .closed(output_closed_q[0]), .flashes(fl0), .last_width(w0));
  strobe_load strobe_load_inst1 (.ref_clk(ref_clk), .rst_n(rst_n),
    .closed(output_closed_q[1]), .flashes(fl1), .last_width(w1));

  // ****************************************
  // Clock, access tasks and verdict
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Line-style write; settings show on the output two edges after the strobe
  task automatic cfg(input logic idx, drv, input logic [3:0] src, input logic pol,
                     input int d, w, input logic lvl);
    @(posedge ref_clk);
    cfg_write <= 1'b1; output_index <= idx; output_drive_mode <= drv;
    pulse_event_source <= src; line_active_polarity <= pol; static_output_level <= lvl;
    line_pulse_delay_us <= d[15:0]; line_pulse_width_us <= w[15:0];
    @(posedge ref_clk) cfg_write <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Selector-style write to the same settings
  task automatic sel(input logic idx, input logic [3:0] code, input int d, w, input logic pol);
    @(posedge ref_clk);
    mode_write <= 1'b1; output_index <= idx; output_event_mode_select <= code;
    pulse_delay_us <= d[15:0]; pulse_width_us <= w[15:0]; pulse_active_polarity <= pol;
    @(posedge ref_clk) mode_write <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // One-cycle event; returns just after the edge that samples it
  task automatic fire(input int e);
    @(posedge ref_clk) ev[e] <= 1'b1;
    @(posedge ref_clk) ev[e] <= 1'b0;
    #1;
  endtask

  // Fire and check the delay and width edges to the exact cycle
  task automatic fire_check(input int idx, e, d, w, input logic pol);
    fire(e);
    repeat (d * CYCLES_PER_US) @(posedge ref_clk);
    #1 `CHK("still_idle", output_closed_q[idx], pol)
    @(posedge ref_clk) #1 `CHK("goes_active", output_closed_q[idx], ~pol)
    repeat (w * CYCLES_PER_US - 1) @(posedge ref_clk);
    #1 `CHK("holds_active", output_closed_q[idx], ~pol)
    @(posedge ref_clk) #1 `CHK("released", output_closed_q[idx], pol)
    @(posedge ref_clk) #1;  // The load learns the width one edge after the fall
    if (!pol) `CHK("load_width", idx ? w1 : w0, w * CYCLES_PER_US)
  endtask

  // ****************************************
  // Watchdog and tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0; checked = 0; rst_n = 1'b0; ev = 8'h00;
    cfg_write = 1'b0; mode_write = 1'b0; output_index = 1'b0; output_drive_mode = 1'b0;
    pulse_event_source = 4'h0; line_active_polarity = 1'b0; static_output_level = 1'b0;
    line_pulse_delay_us = 16'h0000; line_pulse_width_us = 16'h0000;
    output_event_mode_select = 4'h0; pulse_delay_us = 16'h0000; pulse_width_us = 16'h0000;
    pulse_active_polarity = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 `CHK("reset_out", output_closed_q, 2'b00)
    `CHK("reset_rej", rejected_trigger_event_q, 1'b0)
    rst_n <= 1'b1;
    // Static drive on output 2 only, then selector codes 1 and 0 on output 1
    cfg(1'b1, 1'b0, 4'h0, 1'b0, 0, 0, 1'b1);
    `CHK("sw_level", output_closed_q, 2'b10)
    sel(1'b0, MODE_STATIC_CLOSED, 0, 0, 1'b0);
    `CHK("sel_closed", output_closed_q, 2'b11)
    sel(1'b0, MODE_STATIC_OPEN, 0, 0, 1'b0);
    `CHK("sel_open", output_closed_q, 2'b10)
    cfg(1'b1, 1'b0, 4'h0, 1'b0, 0, 0, 1'b0);
    // Event sources 0 to 7 through line-style writes; readout end frees the frame
    for (int s = 0; s < 8; s++) begin
      cfg(1'b0, 1'b1, s[3:0], 1'b0, 1, 1, 1'b0);
      fire_check(0, s, 1, 1, 1'b0);
    end
    // Selector event codes on output 2, active-open polarity, zero delay
    foreach (codes[i]) begin
      sel(1'b1, codes[i][3:0], 0, 2, 1'b1);
      fire_check(1, evts[i], 0, 2, 1'b1);
    end
    // Valid trigger on output 2, rejected trigger on output 1
    sel(1'b1, MODE_VALID_TRIG, 0, 1, 1'b0);
    sel(1'b0, MODE_INVALID_TRIG, 0, 1, 1'b0);
    fire(0);
    `CHK("no_reject", rejected_trigger_event_q, 1'b0)
    @(posedge ref_clk) #1 `CHK("valid_trig", output_closed_q, 2'b10)
    repeat (50) @(posedge ref_clk);
    fire(0);
    `CHK("reject_flag", rejected_trigger_event_q, 1'b1)
    @(posedge ref_clk) #1 `CHK("busy_trig", output_closed_q, 2'b01)
    `CHK("reject_once", rejected_trigger_event_q, 1'b0)
    fire(4);
    repeat (50) @(posedge ref_clk);
    // Second event in mid-delay is dropped; a zero width makes no flash
    cfg(1'b0, 1'b1, SRC_READOUT_START, 1'b0, 1, 1, 1'b0);
    base = fl0;
    fire(3);
    repeat (20) @(posedge ref_clk);
    fire(3);
    repeat (150) @(posedge ref_clk);
    #1 `CHK("one_flash", fl0, base + 1)
    cfg(1'b0, 1'b1, SRC_READOUT_START, 1'b0, 0, 0, 1'b0);
    fire(3);
    repeat (10) @(posedge ref_clk);
    #1 `CHK("zero_width", fl0, base + 1)
    // Illegal source and selector codes must leave output 1 untouched
    cfg(1'b0, 1'b0, 4'h9, 1'b0, 0, 0, 1'b1);
    `CHK("bad_source", output_closed_q[0], 1'b0)
    sel(1'b0, 4'h3, 0, 0, 1'b1);
    `CHK("bad_code", output_closed_q[0], 1'b0)
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire

// ===== rtl/event_output_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
module event_output_pulse_gen
  import pulse_gen_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Line style settings, applied to the output picked by output_index
  input  wire logic              cfg_write,
  input  wire logic              output_index,
  input  wire logic              output_drive_mode,
  input  wire logic [SRC_W-1:0]  pulse_event_source,
  input  wire logic              line_active_polarity,
  input  wire logic [TIME_W-1:0] line_pulse_delay_us,
  input  wire logic [TIME_W-1:0] line_pulse_width_us,
  input  wire logic              static_output_level,
  // Selector style settings for the same output
  input  wire logic              mode_write,
  input  wire logic [3:0]        output_event_mode_select,
  input  wire logic [TIME_W-1:0] pulse_delay_us,
  input  wire logic [TIME_W-1:0] pulse_width_us,
  input  wire logic              pulse_active_polarity,
  // Acquisition sequencer events, one-cycle pulses
  input  wire logic              trigger_in,
  input  wire logic              exposure_start,
  input  wire logic              exposure_end,
  input  wire logic              readout_start,
  input  wire logic              readout_end,
  input  wire logic              acq_stop_sw,
  // Input lines, levels
  input  wire logic              input_line1,
  input  wire logic              input_line2,
  // Opto-coupler drive, 1 = closed
  output var  logic [1:0]        output_closed_q,
  output var  logic              rejected_trigger_event_q
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Selector code to event source; valid flag low for unused codes
  function automatic logic [SRC_W:0] mode_to_source(input logic [3:0] mode);
    logic [SRC_W:0] r;
    r = {1'b0, SRC_TRIGGER_START};
    unique case (mode)
      MODE_STATIC_OPEN:   r = {1'b1, SRC_TRIGGER_START};
      MODE_STATIC_CLOSED: r = {1'b1, SRC_TRIGGER_START};
      MODE_EXPOSE_STROBE: r = {1'b1, SRC_EXPOSE_START};
      MODE_VALID_TRIG:    r = {1'b1, SRC_TRIGGER_START};
      MODE_INVALID_TRIG:  r = {1'b1, SRC_OVER_TRIGGER};
      MODE_READOUT_START: r = {1'b1, SRC_READOUT_START};
      MODE_READOUT_END:   r = {1'b1, SRC_READOUT_END};
      MODE_ACQ_END:       r = {1'b1, SRC_ACQ_END};
      MODE_INPUT_1:       r = {1'b1, SRC_INPUT_1};
      MODE_INPUT_2:       r = {1'b1, SRC_INPUT_2};
      default:            r = {1'b0, SRC_TRIGGER_START};
    endcase
    return r;
  endfunction

  // Source code in range of the event vector
  function automatic logic source_legal(input logic [SRC_W-1:0] src);
    return (src <= SRC_OVER_TRIGGER);
  endfunction

  // ****************************************
  // Per-output settings
  // ****************************************
  logic [1:0]        drive_mode_q;
  logic [SRC_W-1:0]  source_q  [NUM_OUTPUTS];
  logic [1:0]        polarity_q;
  logic [TIME_W-1:0] delay_q   [NUM_OUTPUTS];
  logic [TIME_W-1:0] width_q   [NUM_OUTPUTS];
  logic [1:0]        level_q;
  logic [SRC_W:0]    mode_map;
  logic              line_ok;
  logic              mode_ok;
  logic [1:0]        cfg_hit;

  assign mode_map = mode_to_source(output_event_mode_select);
  assign line_ok  = cfg_write && source_legal(pulse_event_source);
  assign mode_ok  = mode_write && !cfg_write && mode_map[SRC_W];

  // ****************************************
  // Events
  // ****************************************
  logic                  frame_busy_q;
  logic                  in1_q;
  logic                  in2_q;
  logic                  trig_reject;
  logic [NUM_EVENTS-1:0] ev;
  logic [1:0]            fire;
  logic [1:0]            active;
  logic [1:0]            chan_busy;

  // A trigger is refused while the frame it would start cannot be taken
  assign trig_reject = trigger_in && frame_busy_q;

  // Event vector indexed by source code
  assign ev[SRC_TRIGGER_START] = trigger_in && !trig_reject;
  assign ev[SRC_EXPOSE_START]  = exposure_start;
  assign ev[SRC_EXPOSE_END]    = exposure_end;
  assign ev[SRC_READOUT_START] = readout_start;
  assign ev[SRC_READOUT_END]   = readout_end;
  assign ev[SRC_ACQ_END]       = acq_stop_sw;
  assign ev[SRC_INPUT_1]       = input_line1 && !in1_q;
  assign ev[SRC_INPUT_2]       = input_line2 && !in2_q;
  assign ev[SRC_OVER_TRIGGER]  = trig_reject;

  // Frame in progress from an accepted trigger until readout ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_busy_q <= 1'b0;
    end else if (trigger_in && !frame_busy_q) begin
      frame_busy_q <= 1'b1;
    end else if (readout_end) begin
      frame_busy_q <= 1'b0;
    end
  end

  // Previous input levels for rising edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in1_q <= 1'b0;
      in2_q <= 1'b0;
    end else begin
      in1_q <= input_line1;
      in2_q <= input_line2;
    end
  end

  // Rejected trigger indication, one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rejected_trigger_event_q <= 1'b0;
    end else begin
      rejected_trigger_event_q <= trig_reject;
    end
  end

  // ****************************************
  // Output channels
  // ****************************************
  generate
    for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
      // Settings land only on the indexed output
      assign cfg_hit[i] = (line_ok || mode_ok) && (output_index == 1'(i));

      // Settings registers; a selector write rewrites the line settings too, except source for codes 0 and 1 and level for event codes
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          drive_mode_q[i] <= RST_DRIVE_MODE;
          source_q[i]     <= RST_SOURCE;
          polarity_q[i]   <= RST_POLARITY;
          delay_q[i]      <= RST_DELAY_US;
          width_q[i]      <= RST_WIDTH_US;
          level_q[i]      <= RST_LEVEL;
        end else if (cfg_hit[i] && line_ok) begin
          drive_mode_q[i] <= output_drive_mode;
          source_q[i]     <= pulse_event_source;
          polarity_q[i]   <= line_active_polarity;
          delay_q[i]      <= line_pulse_delay_us;
          width_q[i]      <= line_pulse_width_us;
          level_q[i]      <= static_output_level;
        end else if (cfg_hit[i]) begin
          // Codes 0 and 1 are static levels, the rest are event modes
          if (output_event_mode_select == MODE_STATIC_OPEN ||
              output_event_mode_select == MODE_STATIC_CLOSED) begin
            drive_mode_q[i] <= DRIVE_SW;
            level_q[i]      <= output_event_mode_select[0];
          end else begin
            drive_mode_q[i] <= DRIVE_EVENT;
            source_q[i]     <= mode_map[SRC_W-1:0];
          end
          polarity_q[i] <= pulse_active_polarity;
          delay_q[i]    <= pulse_delay_us;
          width_q[i]    <= pulse_width_us;
        end
      end

      // Only the selected source fires, and only in event mode
      assign fire[i] = (drive_mode_q[i] == DRIVE_EVENT) && ev[source_q[i]];

      // Reprogramming drops any pulse in flight so old timing never leaks
      pulse_channel u_chan (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .abort          (cfg_hit[i]),
        .fire           (fire[i]),
        .delay_us       (delay_q[i]),
        .width_us       (width_q[i]),
        .pulse_active_q (active[i]),
        .busy           (chan_busy[i])
      );

      // Idle level is the opposite of the active level; polarity flips both
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          output_closed_q[i] <= RST_LEVEL;
        end else if (drive_mode_q[i] == DRIVE_SW) begin
          output_closed_q[i] <= level_q[i];
        end else begin
          output_closed_q[i] <= active[i] ^ polarity_q[i];
        end
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_readout_start_fire: assert property (
    drive_mode_q[0] && source_q[0] == SRC_READOUT_START && readout_start |-> fire[0])
    else $error("readout start did not fire output 1");
  a_readout_end_fire: assert property (
    drive_mode_q[1] && source_q[1] == SRC_READOUT_END && readout_end |-> fire[1])
    else $error("readout end did not fire output 2");
  a_acq_end_fire: assert property (
    drive_mode_q[0] && source_q[0] == SRC_ACQ_END && acq_stop_sw |-> fire[0])
    else $error("acquisition end did not fire");
  a_input_edge_fire: assert property (
    drive_mode_q[0] && source_q[0] == SRC_INPUT_1 && $rose(input_line1) |-> fire[0])
    else $error("input 1 edge did not fire");
  a_fire_selected_only: assert property (
    fire[0] |-> drive_mode_q[0] && ev[source_q[0]])
    else $error("output fired without its event");
  a_polarity_level: assert property (
    drive_mode_q[1] && $stable(drive_mode_q[1]) |=> output_closed_q[1] ==
      ($past(active[1]) ^ $past(polarity_q[1])))
    else $error("output level disagrees with polarity");
  a_static_level: assert property (
    !drive_mode_q[0] |=> output_closed_q[0] == $past(level_q[0]))
    else $error("static output level wrong");
  a_index_write: assert property (
    line_ok && output_index |=> delay_q[1] == $past(line_pulse_delay_us)
      && $stable(delay_q[0]))
    else $error("settings landed on wrong output");
  a_mode_map: assert property (
    mode_ok && !output_index && output_event_mode_select == MODE_INVALID_TRIG
      |=> drive_mode_q[0] && source_q[0] == SRC_OVER_TRIGGER)
    else $error("selector code mapped wrongly");
  a_drive_mode: assert property (
    line_ok && !output_index |=> drive_mode_q[0] == $past(output_drive_mode))
    else $error("drive mode not taken");
  a_source_legal: assert property (source_legal(source_q[0])
    && source_legal(source_q[1]))
    else $error("event source out of range");
  a_reject_busy: assert property (
    trigger_in && frame_busy_q |-> !ev[SRC_TRIGGER_START] ##1 rejected_trigger_event_q)
    else $error("trigger in busy frame not rejected");
  a_busy_no_restart: assert property (
    chan_busy[0] && !cfg_hit[0] && fire[0] && g_out[0].u_chan.cnt_q != 22'h000000
      |=> g_out[0].u_chan.cnt_q == $past(g_out[0].u_chan.cnt_q) - 22'h000001)
    else $error("busy output disturbed by event");
  a_release_idle: assert property (
    $fell(chan_busy[0]) && drive_mode_q[0] && !$past(cfg_hit[0]) && !cfg_hit[0]
      |=> output_closed_q[0] == polarity_q[0])
    else $error("output not back to idle level");
  a_static_code: assert property (
    mode_ok && !output_index && output_event_mode_select == MODE_STATIC_CLOSED
      |=> !drive_mode_q[0] && level_q[0])
    else $error("static selector code not applied");
  a_bad_source_kept: assert property (
    cfg_write && !source_legal(pulse_event_source)
      |=> $stable(drive_mode_q) && $stable(level_q) && $stable(polarity_q))
    else $error("illegal event source write was taken");
  a_input2_fire: assert property (
    drive_mode_q[1] && source_q[1] == SRC_INPUT_2 && $rose(input_line2) |-> fire[1])
    else $error("input 2 edge did not fire");
  a_event_gate: assert property (
    !drive_mode_q[1] |-> !fire[1])
    else $error("software driven output fired");
  a_reject_pulse: assert property (
    rejected_trigger_event_q |-> $past(trigger_in) && $past(frame_busy_q))
    else $error("rejected flag without a refused trigger");
  a_frame_mark: assert property (
    trigger_in && !frame_busy_q |=> frame_busy_q)
    else $error("accepted trigger did not mark the frame");

  c_readout_pulse: cover property (fire[0] && source_q[0] == SRC_READOUT_START);
  c_rejected_trig: cover property (rejected_trigger_event_q);
  c_both_active:   cover property (active[0] && active[1]);
  c_static_close:  cover property (!drive_mode_q[1] && output_closed_q[1]);

endmodule
`default_nettype wire

// ===== rtl/pulse_channel.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_channel
  import pulse_gen_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              abort,
  input  wire logic              fire,
  input  wire logic [TIME_W-1:0] delay_us,
  input  wire logic [TIME_W-1:0] width_us,
  output var  logic              pulse_active_q,
  output var  logic              busy
);

  chan_state_t      state_q;
  chan_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] dly_cyc;
  logic [CNT_W-1:0] wid_cyc;

  // ****************************************
  // Microsecond scaling
  // ****************************************
  // Counting in cycles restarted at the event keeps timing exact, no tick jitter
  assign dly_cyc = CNT_W'({6'h00, delay_us} * CYC_PER_US_W);
  assign wid_cyc = CNT_W'({6'h00, width_us} * CYC_PER_US_W);
  assign busy    = (state_q != CH_IDLE);

  // ****************************************
  // Delay then pulse sequencer
  // ****************************************
  // Next state; a fire while busy falls through untouched
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      CH_IDLE: begin
        if (fire) begin
          if (delay_us != 16'h0000) begin
            state_d = CH_DELAY;
            cnt_d   = dly_cyc - 22'h000001;
          end else if (width_us != 16'h0000) begin
            state_d = CH_PULSE;
            cnt_d   = wid_cyc - 22'h000001;
          end
        end
      end
      CH_DELAY: begin
        if (cnt_q == 22'h000000) begin
          state_d = (width_us != 16'h0000) ? CH_PULSE : CH_IDLE;
          cnt_d   = wid_cyc - 22'h000001;
        end else begin
          cnt_d = cnt_q - 22'h000001;
        end
      end
      CH_PULSE: begin
        if (cnt_q == 22'h000000) begin
          state_d = CH_IDLE;
        end else begin
          cnt_d = cnt_q - 22'h000001;
        end
      end
      default: begin
        state_d = CH_IDLE;
        cnt_d   = 22'h000000;
      end
    endcase
    if (abort) begin
      state_d = CH_IDLE;
      cnt_d   = 22'h000000;
    end
  end

  // State and counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CH_IDLE;
      cnt_q   <= 22'h000000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Active flag follows the sequencer with no extra lag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_active_q <= 1'b0;
    end else begin
      pulse_active_q <= (state_d == CH_PULSE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [CNT_W:0] elapsed_q;
  logic [CNT_W:0] dly_exp_q;
  logic [CNT_W:0] wid_exp_q;

  // Cycles since the last accepted event, for timing checks only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_q <= 23'h000000;
      dly_exp_q <= 23'h000000;
      wid_exp_q <= 23'h000000;
    end else if (state_q == CH_IDLE && fire && !abort) begin
      elapsed_q <= 23'h000000;
      dly_exp_q <= {1'b0, dly_cyc};
      wid_exp_q <= {1'b0, wid_cyc};
    end else if (elapsed_q != 23'h7fffff) begin
      elapsed_q <= elapsed_q + 23'h000001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_delay_exact: assert property ($rose(pulse_active_q) |-> elapsed_q == dly_exp_q)
    else $error("pulse rose at wrong delay");
  a_width_exact: assert property (
    $fell(pulse_active_q) && !$past(abort) |-> elapsed_q == dly_exp_q + wid_exp_q)
    else $error("pulse ended at wrong width");
  a_busy_ignore: assert property (
    state_q == CH_DELAY && cnt_q != 22'h000000 && fire && !abort
      |=> state_q == CH_DELAY && cnt_q == $past(cnt_q) - 22'h000001)
    else $error("event restarted a busy output");
  a_pulse_release: assert property (
    state_q == CH_PULSE && cnt_q == 22'h000000 |=> !pulse_active_q && !busy)
    else $error("pulse not released at end");

  c_full_pulse: cover property (
    state_q == CH_DELAY ##1 state_q == CH_DELAY [*2] ##[1:1000] $fell(pulse_active_q));
  c_busy_fire:  cover property (busy && fire);

endmodule
`default_nettype wire

// ===== rtl/pulse_gen_pkg.sv
`default_nettype none
package pulse_gen_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 25;    // 40 MHz reference
  localparam int unsigned TICK_PERIOD_NS = 1000;  // One microsecond
  localparam int unsigned CYCLES_PER_US  =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned NUM_OUTPUTS = 2;
  localparam int unsigned TIME_W      = 16;  // Delay and width, 0 to 64k us
  localparam int unsigned CNT_W       = 22;  // Holds 65535 us in cycles
  localparam int unsigned SRC_W       = 4;
  localparam int unsigned NUM_EVENTS  = 9;

  localparam logic [CNT_W-1:0] CYC_PER_US_W = CNT_W'(CYCLES_PER_US);

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic {
    DRIVE_SW    = 1'b0,  // sw_static_drive
    DRIVE_EVENT = 1'b1   // event_triggered_drive
  } drive_mode_t;

  typedef enum logic [SRC_W-1:0] {
    SRC_TRIGGER_START = 4'h0,
    SRC_EXPOSE_START  = 4'h1,
    SRC_EXPOSE_END    = 4'h2,
    SRC_READOUT_START = 4'h3,
    SRC_READOUT_END   = 4'h4,
    SRC_ACQ_END       = 4'h5,
    SRC_INPUT_1       = 4'h6,
    SRC_INPUT_2       = 4'h7,
    SRC_OVER_TRIGGER  = 4'h8
  } event_src_t;

  // Per-output event mode selector codes
  localparam logic [3:0] MODE_STATIC_OPEN   = 4'h0;
  localparam logic [3:0] MODE_STATIC_CLOSED = 4'h1;
  localparam logic [3:0] MODE_EXPOSE_STROBE = 4'h2;
  localparam logic [3:0] MODE_VALID_TRIG    = 4'h4;
  localparam logic [3:0] MODE_INVALID_TRIG  = 4'h5;
  localparam logic [3:0] MODE_READOUT_START = 4'h6;
  localparam logic [3:0] MODE_READOUT_END   = 4'h7;
  localparam logic [3:0] MODE_ACQ_END       = 4'h8;
  localparam logic [3:0] MODE_INPUT_1       = 4'h9;
  localparam logic [3:0] MODE_INPUT_2       = 4'ha;

  typedef enum logic [1:0] {
    CH_IDLE  = 2'b00,
    CH_DELAY = 2'b01,
    CH_PULSE = 2'b10
  } chan_state_t;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic              RST_DRIVE_MODE = 1'b0;
  localparam logic [SRC_W-1:0]  RST_SOURCE     = 4'h0;
  localparam logic              RST_POLARITY   = 1'b0;
  localparam logic [TIME_W-1:0] RST_DELAY_US   = 16'h0000;
  localparam logic [TIME_W-1:0] RST_WIDTH_US   = 16'h0000;
  localparam logic              RST_LEVEL      = 1'b0;  // Open

endpackage
`default_nettype wire
